// file: test_tws_eeprom.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the serial EEPROM block
module test_tws_eeprom;
	import tws_pkg::*;
	// Shortened write cycle
	localparam int TWC = 400;
	logic clk_i, rst_n_i, wp_i, scl, m_oe_n, sda_o, dut_oe_n, k;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata, seed;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] mem_m [0:511];
	int fails, check_count;
	// Open-drain wire with pull-up
	wire logic sda = m_oe_n & dut_oe_n;

	tws_eeprom #(.TWC_CYC(TWC), .AW(8)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(dut_oe_n), .wp_i(wp_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	tws_master_model i_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// ==========================================================
	// Expectation helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr_next
	// Page slot of the i-th data byte
	function automatic logic [8:0] slot(input logic [8:0] a, input int i);
		return {a[8:4], a[3:0] + 4'(i)};
	endfunction : slot
	task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : cmp_val
	task automatic cmp_ack(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %b, seen %b", what, e, g);
		end
	endtask : cmp_ack
	task automatic tally_and_finish;
		if (fails == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// Register bus master, flags sampled before each edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, pb, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pb) begin
			@(negedge clk_i);
			ta = pa & awready;
			tw = pw & wready;
			pb = !bvalid;
			if (!pb) cmp_val("write response", 32'(RESP_OKAY), 32'(bresp));
			@(posedge clk_i);
			if (ta) awvalid <= 1'b0;
			if (ta) pa = 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tw) pw = 1'b0;
			if (!pb) bready <= 1'b0;
		end
	endtask : axi_wr
	task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic done, ta;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge clk_i);
			ta = arvalid & arready;
			done = rvalid;
			if (done) cmp_val("read data", e, rdata);
			if (done) cmp_val("read response", 32'(er), 32'(rresp));
			@(posedge clk_i);
			if (ta) arvalid <= 1'b0;
		end
	endtask : reg_chk
	// ==========================================================
	// Serial sequences
	task automatic ctrl(input logic rw, input logic b, output logic ack);
		seed = lfsr_next(seed);
		i_master.start();
		// type code, random ignored bits, block, direction
		i_master.send({DEV_CODE, seed[1:0], b, rw}, ack);
	endtask : ctrl
	task automatic set_addr(input logic [8:0] a);
		ctrl(1'b0, a[8], k);
		cmp_ack("control ack", 1'b1, k);
		i_master.send(a[7:0], k);
		cmp_ack("address ack", 1'b1, k);
	endtask : set_addr
	task automatic wr_seq(input logic [8:0] a, input int n, input logic prot);
		set_addr(a);
		for (int i = 0; i < n; i++) begin
			seed = lfsr_next(seed);
			i_master.send(seed[7:0], k);
			cmp_ack("data ack", 1'b1, k);
			if (!prot) mem_m[slot(a, i)] = seed[7:0];
		end
		i_master.stop();
	endtask : wr_seq
	task automatic rd_seq(input logic [8:0] a, input int n);
		set_addr(a);
		ctrl(1'b1, a[8], k);
		cmp_ack("read control ack", 1'b1, k);
		for (int i = 0; i < n; i++) begin
			i_master.recv(i < n - 1, d);
			cmp_val("read byte", 32'(mem_m[a + 9'(i)]), 32'(d));
		end
		i_master.stop();
	endtask : rd_seq
	task automatic poll(input logic e);
		ctrl(1'b0, 1'b0, k);
		i_master.stop();
		cmp_ack("poll ack", e, k);
	endtask : poll
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n_i, wp_i, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata} = 48'h0;
		fails = 0;
		check_count = 0;
		seed = 32'h9DB1;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		reg_chk(CTRL_OFS, 32'h1, RESP_OKAY);
		reg_chk(WCNT_OFS, 32'h0, RESP_OKAY);
		reg_chk(8'h0C, 32'h0, RESP_DECERR);
		wr_seq(9'h1FF, 1, 1'b0);
		poll(1'b0);
		repeat (TWC) @(posedge clk_i);
		poll(1'b1);
		wr_seq(9'h000, 18, 1'b0);
		repeat (TWC) @(posedge clk_i);
		ctrl(1'b1, 1'b0, k);
		cmp_ack("current control ack", 1'b1, k);
		i_master.recv(1'b0, d);
		cmp_val("current byte", 32'(mem_m[2]), 32'(d));
		i_master.stop();
		rd_seq(9'h1FF, 2);
		rd_seq(9'h000, 16);
		i_master.start();
		i_master.send(8'hB0, k);
		cmp_ack("foreign code ack", 1'b0, k);
		i_master.stop();
		wp_i <= 1'b1;
		wr_seq(9'h005, 1, 1'b1);
		poll(1'b1);
		rd_seq(9'h005, 1);
		reg_chk(STAT_OFS, 32'h6 << STAT_PTR_LSB | 32'h1 << STAT_WP_BIT, RESP_OKAY);
		reg_chk(WCNT_OFS, 32'h2, RESP_OKAY);
		wp_i <= 1'b0;
		axi_wr(CTRL_OFS, 32'h0);
		poll(1'b0);
		axi_wr(CTRL_OFS, 32'h1);
		poll(1'b1);
		tally_and_finish();
	end
	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk_i);
		fails++;
		tally_and_finish();
	end
endmodule : test_tws_eeprom

// file: tws_eeprom.sv
`timescale 1ns/10ps
// Contract
// [R1] SDA changes only while serial clock low
// [R2] Overlong writes keep newest sixteen bytes
// [R3] Every addressed byte gets an acknowledge
// [R4] No acknowledge during internal programming
// [R5] Acknowledge holds SDA low through clock high
// [R6] Missing master acknowledge ends read, releases SDA
// [R7] Control byte type code is 1010
// [R8] Two bits ignored, block select is MSB
// [R9] Last control bit: 1 read, 0 write
// [R10] Acknowledge matching code only, then branch direction
// [R11] Byte write: control, address, data, each acknowledged
// [R12] Stop after write data launches write cycle
// [R13] Page data buffered, committed at Stop
// [R14] Only low four pointer bits increment on write
// [R15] Master keeps page writes inside one page
// [R16] Polling: no acknowledge until write done
// [R17] Write protect inhibits all programming
// [R18] Current read returns word after last access
// [R19] Address-only write sets pointer, no cycle
// [R20] Master acknowledge advances pointer, next byte sent
// [R21] Start: SDA falls while clock high
// [R22] Stop: SDA rises while clock high
// [R23] Write cycle ends within 5 ms
// [R24] Write protect leaves reads unchanged
// [R25] Read pointer wraps from top to zero
// [R26] Protected write acknowledged, never launched
module tws_eeprom #(
	// Write cycle length in clock cycles
	parameter int TWC_CYC = tws_pkg::TWC_CYC_DEF,
	// Register bus address width
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	// Write protect pin
	input wire logic wp_i,
	// Register bus, write address and data
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// Register bus, write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// Register bus, read address and data
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	import tws_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (TWC_CYC < 1 || TWC_CYC >= (1 << CNT_W)) begin : g_bad_twc
		$error("TWC_CYC out of range");
	end
	if (AW < 8) begin : g_bad_aw
		$error("AW too small for register map");
	end

	// ==========================================================
	// Declarations
	logic [2:0] pin_s; // Synchronised pins
	// Delayed copies for edge detection
	logic scl_q_r;
	logic sda_q_r;
	// Engine state and the state after an acknowledge
	tws_state_t state_r;
	tws_state_t ret_r;
	logic [3:0] bit_cnt_r; // Bits seen in the current byte
	logic [7:0] rx_r; // Receive shift register
	logic [7:0] tx_r; // Transmit shift register, MSB on the wire
	logic ack_drv_r; // Device pulls SDA low for an acknowledge
	logic m_ack_r; // Master acknowledged the last read byte
	logic blk_r; // Block select captured from the control byte
	logic [MEM_AW-1:0] ptr_r; // Address pointer
	// Page buffer, its valid bits and the page it targets
	logic [7:0] pbuf_r [PAGE_SZ];
	logic [PAGE_SZ-1:0] vld_r;
	logic [MEM_AW-PAGE_AW-1:0] page_r;
	// Internal write cycle
	logic busy_r;
	logic [CNT_W-1:0] wc_cnt_r;
	logic [15:0] wcnt_r;
	logic [7:0] mem_r [MEM_SZ]; // Memory array
	logic en_w; // Software enable
	tws_stat_t stat_w; // Status bundle

	// ==========================================================
	// Pin sampling and bus conditions
	tws_sync #(
		.W(3),
		.RST_VAL(PIN_RST)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i({scl_i, sda_i, wp_i}),
		.q_o(pin_s)
	);

	// Named views of the synchronised pins
	wire scl_s = pin_s[2];
	wire sda_s = pin_s[1];
	wire wp_s = pin_s[0];

	// Edge history of the synchronised pins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	// Clock edges
	wire scl_rise = scl_s & ~scl_q_r;
	wire scl_fall = ~scl_s & scl_q_r;
	// [R21] start detection
	wire start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
	// [R22] stop detection
	wire stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;
	wire byte_end = scl_fall & (bit_cnt_r == BYTE_BITS); // Fall after eight bits
	// [R7] type code match
	wire code_ok = rx_r[7:4] == DEV_CODE;
	// [R4] silent while programming or disabled
	wire can_ack = en_w & ~busy_r;
	// [R24] reads use the array regardless of protection
	wire [7:0] rd_byte = mem_r[ptr_r];
	wire wr_byte = byte_end & (state_r == ST_WDATA) & can_ack; // Byte into page buffer
	// [R12] stop after buffered data launches a cycle
	// [R17] protection blocks the launch
	// [R26] protected data was acknowledged but dropped here
	// [R19] no buffered data, no cycle
	wire launch = stop_det & (|vld_r) & ~wp_s & ~busy_r;

	// ==========================================================
	// Pin drive
	assign sda_o = 1'b0; // Open drain: only ever pulls low
	// [R1] drive sources change only after a clock fall
	// [R6] released high once a read ends
	assign sda_oe_n_o = ~(ack_drv_r | ((state_r == ST_TX) & ~tx_r[7]));

	// ==========================================================
	// Serial engine
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			ret_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			rx_r <= 8'h00;
			tx_r <= 8'hFF;
			ack_drv_r <= 1'b0;
			m_ack_r <= 1'b0;
			blk_r <= 1'b0;
			ptr_r <= '0;
		end else if (start_det) begin
			// [R21] every command begins here
			state_r <= ST_CTRL;
			bit_cnt_r <= 4'h0;
			ack_drv_r <= 1'b0;
			tx_r <= 8'hFF;
		end else if (stop_det) begin
			// [R22] operation ends, bus released
			state_r <= ST_IDLE;
			ack_drv_r <= 1'b0;
			tx_r <= 8'hFF;
		end else begin
			case (state_r)
				// Waiting for a start
				ST_IDLE: begin
					bit_cnt_r <= 4'h0;
				end
				// Receiving a byte from the master
				ST_CTRL, ST_ADDR, ST_WDATA: begin
					if (scl_rise) begin
						// [R1] sample while clock high
						rx_r <= {rx_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_end) begin
						bit_cnt_r <= 4'h0;
						if (!can_ack || (state_r == ST_CTRL && !code_ok)) begin
							// [R10] no match, stay silent
							// [R16] busy polling gets no acknowledge
							state_r <= ST_IDLE;
						end else begin
							// [R3] acknowledge the byte
							// [R11] control, address and data alike
							state_r <= ST_ACK;
							ack_drv_r <= 1'b1;
							if (state_r == ST_CTRL) begin
								// [R8] bits 3:2 ignored, bit 1 selects block
								blk_r <= rx_r[1];
								// [R9] direction bit chooses read or write
								ret_r <= rx_r[0] ? ST_TX : ST_ADDR;
							end else if (state_r == ST_ADDR) begin
								// [R19] pointer latched from address byte
								ptr_r <= {blk_r, rx_r};
								ret_r <= ST_WDATA;
							end else begin
								// [R14] low four bits advance, page fixed
								// [R15] overrun wraps within the page
								ptr_r <= {ptr_r[MEM_AW-1:PAGE_AW], ptr_r[PAGE_AW-1:0] + 4'h1};
								ret_r <= ST_WDATA;
							end
						end
					end
				end
				// Acknowledge bit driven by the device
				ST_ACK: begin
					if (scl_fall) begin
						// [R5] held low across the whole clock high
						ack_drv_r <= 1'b0;
						state_r <= ret_r;
						// [R18] first byte from the current pointer
						tx_r <= (ret_r == ST_TX) ? rd_byte : 8'hFF;
					end
				end
				// Transmitting a byte to the master
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_end) begin
						bit_cnt_r <= 4'h0;
						state_r <= ST_RACK;
						m_ack_r <= 1'b0;
						tx_r <= 8'hFF;
						// [R25] nine-bit pointer wraps to zero
						// [R18] pointer ends one past the word sent
						ptr_r <= ptr_r + 9'h001;
					end else if (scl_fall) begin
						// [R1] next bit after the clock falls
						tx_r <= {tx_r[6:0], 1'b1};
					end
				end
				// Acknowledge bit driven by the master
				ST_RACK: begin
					if (scl_rise) begin
						m_ack_r <= ~sda_s;
					end else if (scl_fall) begin
						if (m_ack_r) begin
							// [R20] next sequential byte
							state_r <= ST_TX;
							tx_r <= rd_byte;
						end else begin
							// [R6] no acknowledge ends the read
							state_r <= ST_IDLE;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Page buffer, indexed by the low pointer bits
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			vld_r <= '0;
			page_r <= '0;
		end else if (start_det || stop_det) begin
			// Each transaction starts with an empty buffer
			vld_r <= '0;
		end else if (wr_byte) begin
			// [R2] newer bytes replace older ones in place
			// [R13] held until stop
			vld_r[ptr_r[PAGE_AW-1:0]] <= 1'b1;
			page_r <= ptr_r[MEM_AW-1:PAGE_AW];
		end
	end

	// Buffer data, no reset needed
	always_ff @(posedge clk_i) begin
		if (wr_byte) begin
			pbuf_r[ptr_r[PAGE_AW-1:0]] <= rx_r;
		end
	end

	// ==========================================================
	// Memory array
	// [R13] commit every buffered byte at launch
	always_ff @(posedge clk_i) begin
		if (launch) begin
			for (int i = 0; i < PAGE_SZ; i++) begin
				if (vld_r[i]) begin
					mem_r[{page_r, PAGE_AW'(i)}] <= pbuf_r[i];
				end
			end
		end
	end

	// ==========================================================
	// Internal write cycle timer
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_r <= 1'b0;
			wc_cnt_r <= '0;
			wcnt_r <= 16'h0000;
		end else if (launch) begin
			// [R12] self-timed cycle begins
			busy_r <= 1'b1;
			wc_cnt_r <= CNT_W'(TWC_CYC - 1);
			wcnt_r <= wcnt_r + 16'h0001;
		end else if (busy_r) begin
			// [R23] ends after TWC_CYC cycles
			if (wc_cnt_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				wc_cnt_r <= wc_cnt_r - CNT_W'(1);
			end
		end
	end

	// ==========================================================
	// Software registers and the status bundle
	assign stat_w.busy = busy_r;
	assign stat_w.wp = wp_s;
	assign stat_w.active = state_r != ST_IDLE;
	assign stat_w.ptr = ptr_r;
	assign stat_w.wcnt = wcnt_r;

	// Register slave
	tws_regs #(
		.AW(AW)
	) u_regs (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.stat_i(stat_w),
		.en_o(en_w)
	);
endmodule : tws_eeprom

// file: tws_eeprom_properties.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the serial EEPROM block
module tws_eeprom_properties #(
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	// Register bus
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	import tws_pkg::*;
	// One domain, reset disables all checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Bus framing events seen on the pins
	sequence start_seq; scl_i && $fell(sda_i); endsequence
	sequence stop_seq; scl_i && $rose(sda_i); endsequence
	// Unmapped read address
	wire logic bad_addr = s_axi_araddr_i != AW'(CTRL_OFS) && s_axi_araddr_i != AW'(STAT_OFS)
		&& s_axi_araddr_i != AW'(WCNT_OFS);

	chk_sda_low_only: assert property (sda_o == 1'b0)
		else $error("data pin output not low");
	chk_scl_high_hold: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
		else $error("data drive changed while clock high");
	chk_start_quiet: assert property (start_seq |-> sda_oe_n_o [*8])
		else $error("data driven right after start");
	chk_stop_quiet: assert property (stop_seq |-> sda_oe_n_o [*8])
		else $error("data driven right after stop");
	chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> ##1 s_axi_bvalid_o)
		else $error("write response late");
	chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
		&& $stable(s_axi_bresp_o))
		else $error("write response dropped");
	chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read response late");
	chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read response dropped");
	chk_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while busy");
	chk_unmapped_read: assert property (s_axi_arvalid_i && s_axi_arready_o && bad_addr
		|=> s_axi_rresp_o == RESP_DECERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
endmodule : tws_eeprom_properties

bind tws_eeprom tws_eeprom_properties #(.AW(AW)) i_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

// file: tws_master_model.sv
`timescale 1ns/10ps
// ==========================================================
// Two-wire bus master, clock still between frames
module tws_master_model (
	// Clock
	input wire logic clk_i,
	// Bus wires
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_n_o
);
	// Idle bus: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	// Quarter of the 320 ns serial period
	task automatic quarter;
		repeat (2) @(posedge clk_i);
	endtask : quarter
	task automatic pulse(input logic bit_v, output logic seen);
		sda_oe_n_o <= bit_v;
		quarter();
		scl_o <= 1'b1;
		quarter();
		seen = sda_i;
		quarter();
		scl_o <= 1'b0;
		quarter();
	endtask : pulse
	task automatic start;
		sda_oe_n_o <= 1'b1;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_oe_n_o <= 1'b0;
		quarter();
		scl_o <= 1'b0;
		quarter();
	endtask : start
	task automatic stop;
		sda_oe_n_o <= 1'b0;
		quarter();
		scl_o <= 1'b1;
		quarter();
		sda_oe_n_o <= 1'b1;
		quarter();
	endtask : stop
	// byte out, ninth pulse left for the answer
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(b[i], s);
		pulse(1'b1, s);
		ack = ~s;
	endtask : send
	// byte in, then answer or withhold
	task automatic recv(input logic give_ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(1'b1, b[i]);
		pulse(~give_ack, s);
	endtask : recv
endmodule : tws_master_model

// file: tws_pkg.sv
package tws_pkg;
	// ==========================================================
	// Register map, byte addresses on the register bus
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] WCNT_OFS = 8'h08;
	// Control register fields and reset value
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WP_BIT = 1;
	localparam int STAT_ACT_BIT = 2;
	localparam int STAT_PTR_LSB = 4;
	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// Memory organisation
	localparam int MEM_AW = 9;
	localparam int PAGE_AW = 4;
	localparam int MEM_SZ = 1 << MEM_AW;
	localparam int PAGE_SZ = 1 << PAGE_AW;
	// Device type code in the control byte
	localparam logic [3:0] DEV_CODE = 4'hA;
	// Bits per byte on the serial bus
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Idle levels of the sampled pins {scl, sda, wp}
	localparam logic [2:0] PIN_RST = 3'h6;

	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 25_000_000;
	// Longest write cycle, in milliseconds
	localparam longint TWC_MS = 5;
	// Longest time rounds down to whole cycles
	localparam int TWC_CYC_DEF = int'((TWC_MS * CLK_HZ) / 1000);
	// Width of the write cycle counter
	localparam int CNT_W = 24;

	// ==========================================================
	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_ADDR = 3'h2,
		ST_WDATA = 3'h3,
		ST_ACK = 3'h4,
		ST_TX = 3'h5,
		ST_RACK = 3'h6
	} tws_state_t;

	// Engine status shown to software
	typedef struct packed {
		logic busy;
		logic wp;
		logic active;
		logic [MEM_AW-1:0] ptr;
		logic [15:0] wcnt;
	} tws_stat_t;
endpackage : tws_pkg

// file: tws_regs.sv
`timescale 1ns/10ps
// ==========================================================
// AXI4-Lite register slave
module tws_regs #(
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Write address and data
	input wire logic [AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// Write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// Read address and data
	input wire logic [AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Engine side
	input wire tws_pkg::tws_stat_t stat_i,
	output logic en_o
);
	import tws_pkg::*;

	// Captured write halves
	logic aw_have_r;
	logic w_have_r;
	logic [AW-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	// Status word assembled from engine state
	logic [31:0] stat_w;

	// Decode of the captured write address
	wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid_o;
	wire wr_ctrl = awaddr_r == AW'(CTRL_OFS);
	wire wr_hit = wr_ctrl | (awaddr_r == AW'(STAT_OFS)) | (awaddr_r == AW'(WCNT_OFS));
	// Decode of the read address
	wire rd_ctrl = s_axi_araddr_i == AW'(CTRL_OFS);
	wire rd_stat = s_axi_araddr_i == AW'(STAT_OFS);
	wire rd_wcnt = s_axi_araddr_i == AW'(WCNT_OFS);
	wire rd_hit = rd_ctrl | rd_stat | rd_wcnt;
	wire [31:0] rd_mux = rd_ctrl ? {31'h0, en_o} : rd_stat ? stat_w : rd_wcnt ? {16'h0, stat_i.wcnt} : 32'h0;
	// Each half is taken once and held until the response
	assign s_axi_awready_o = ~aw_have_r;
	assign s_axi_wready_o = ~w_have_r;
	assign s_axi_arready_o = ~s_axi_rvalid_o;

	// Status word layout
	always_comb begin
		stat_w = 32'h0;
		stat_w[STAT_BUSY_BIT] = stat_i.busy;
		stat_w[STAT_WP_BIT] = stat_i.wp;
		stat_w[STAT_ACT_BIT] = stat_i.active;
		stat_w[STAT_PTR_LSB +: MEM_AW] = stat_i.ptr;
	end

	// Write channel: halves in either order, response after both
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			en_o <= CTRL_EN_RST;
		end else begin
			// Capture address
			if (s_axi_awvalid_i && !aw_have_r) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_i;
			end
			// Capture data
			if (s_axi_wvalid_i && !w_have_r) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end
			// Perform the write and answer
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_DECERR;
				if (wr_ctrl && wstrb_r[0]) begin
					en_o <= wdata_r[CTRL_EN_BIT];
				end
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_mux;
			s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end
endmodule : tws_regs

// file: tws_sync.sv
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for a group of pin inputs
module tws_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous inputs and their synchronised copy
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// First stage, read only by the second stage
	logic [W-1:0] meta_r;

	// Two flip-flops in series
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : tws_sync
